// >>> bench/tb_top.sv
// tb_top.sv: self-checking bench for the flash, eeprom and watchdog sfr bank
// assumes: fwm_pkg and fwm_sfr_bank compiled first; 40 MHz clock, mpu strobes one cycle
`timescale 1ns/1ps
module tb_top;
  logic clk, nrst, wr_s, rd_s, gie, dbg, pre, fdone, xev, sev;
  logic [7:0] addr, wdata, rdata, ee_b, ee_c, d;
  logic [6:0] ext, epage;
  logic pe, me, pwe, rp, launch, wdr, xf, sf;
  int n_fail = 0;
  int samples_checked = 0;
  // trigger values that must start nothing
  logic [7:0] bad_pat [6] = '{8'h00, 8'h54, 8'h56, 8'ha9, 8'hab, 8'hff};

  // device under test
  fwm_sfr_bank i_fwm_sfr_bank (.sys_clk_i(clk), .nrst_i(nrst), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_wr_i(wr_s), .sfr_rd_i(rd_s), .sfr_rdata_o(rdata),
    .global_irq_en_i(gie), .debug_port_en_i(dbg), .preboot_active_i(pre),
    .flash_byte_done_i(fdone), .transfer_busy_event_i(xev), .one_second_event_i(sev),
    .ext_irq_inputs_i(ext), .page_erase_start_o(pe), .mass_erase_start_o(me),
    .erase_page_o(epage), .program_write_enable_o(pwe), .read_protection_o(rp),
    .serial_eeprom_byte_o(ee_b), .serial_eeprom_command_o(ee_c), .eeprom_launch_o(launch),
    .watchdog_restart_o(wdr), .transfer_done_flag_o(xf), .second_tick_flag_o(sf));

  // 25 ns clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one-cycle write strobe, effect visible on return
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    addr = a;
    wdata = v;
    wr_s = 1'b1;
    @(posedge clk);
    #1;
    wr_s = 1'b0;
  endtask : wr

  // one-cycle read strobe, data registered on return
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1;
    addr = a;
    rd_s = 1'b1;
    @(posedge clk);
    #1;
    rd_s = 1'b0;
    v = rdata;
  endtask : rd

  // one-cycle pulse on {flash byte done, busy event, second event}
  task automatic ev(input logic [2:0] v);
    @(posedge clk);
    #1;
    {fdone, xev, sev} = v;
    @(posedge clk);
    #1;
    {fdone, xev, sev} = 3'b000;
  endtask : ev

  // trigger write and check both erase pulses
  task automatic trig(input logic [7:0] v, input logic ep, input logic em);
    wr(8'h94, v);
    chk("page_erase_start", {7'h00, pe}, {7'h00, ep});
    chk("mass_erase_start", {7'h00, me}, {7'h00, em});
  endtask : trig

  // verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // hang guard, run needs about a hundred cycles
  initial
  begin
    #(25 * 4000);
    n_fail++;
    close_out();
  end

  // main sequence
  initial
  begin
    {nrst, wr_s, rd_s, gie, dbg, pre, fdone, xev, sev} = 9'h000;
    addr = 8'h00;
    wdata = 8'h00;
    ext = 7'h00;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    rd(8'h94, d);
    chk("erase_trigger", d, 8'h00);
    rd(8'hb7, d);
    chk("page_select", d, 8'h00);
    rd(8'hb2, d);
    chk("flash_ctrl", d, 8'h00);
    chk("outputs", {pe, me, pwe, rp, launch, wdr, xf, sf}, 8'h00);
    $display("test reset done");
    wr(8'hb7, 8'h7f);
    rd(8'hb7, d);
    chk("page_select", d, 8'h7f);
    chk("erase_page", {1'b0, epage}, 8'h7f);
    trig(8'h55, 1'b1, 1'b0);
    // start pulse must be gone one cycle later
    @(posedge clk);
    #1;
    chk("page_pulse_len", {7'h00, pe}, 8'h00);
    trig(8'h55, 1'b0, 1'b0);
    wr(8'hb7, 8'h03);
    foreach (bad_pat[i])
      trig(bad_pat[i], 1'b0, 1'b0);
    trig(8'haa, 1'b0, 1'b0);
    trig(8'h55, 1'b1, 1'b0);
    $display("test page erase done");
    dbg = 1'b1;
    wr(8'hb2, 8'h02);
    trig(8'haa, 1'b0, 1'b1);
    trig(8'haa, 1'b0, 1'b0);
    dbg = 1'b0;
    wr(8'hb2, 8'h02);
    trig(8'haa, 1'b0, 1'b0);
    dbg = 1'b1;
    trig(8'haa, 1'b0, 1'b1);
    $display("test mass erase done");
    gie = 1'b1;
    wr(8'hb2, 8'h01);
    chk("pwe_blocked", {7'h00, pwe}, 8'h00);
    gie = 1'b0;
    wr(8'hb2, 8'h01);
    chk("pwe_set", {7'h00, pwe}, 8'h01);
    rd(8'hb2, d);
    chk("flash_ctrl", d, 8'h01);
    ev(3'b100);
    chk("pwe_autoclear", {7'h00, pwe}, 8'h00);
    wr(8'hb2, 8'h40);
    chk("read_prot", {7'h00, rp}, 8'h01);
    wr(8'hb2, 8'h00);
    chk("read_prot", {7'h00, rp}, 8'h01);
    pre = 1'b1;
    rd(8'hb2, d);
    chk("flash_ctrl", d, 8'hc0);
    pre = 1'b0;
    $display("test flash control done");
    wr(8'h9e, 8'ha5);
    chk("eeprom_launch", {7'h00, launch}, 8'h00);
    wr(8'h9f, 8'h03);
    chk("eeprom_launch", {7'h00, launch}, 8'h01);
    chk("eeprom_byte", ee_b, 8'ha5);
    chk("eeprom_cmd", ee_c, 8'h03);
    rd(8'h9e, d);
    chk("eeprom_byte_rd", d, 8'ha5);
    $display("test eeprom done");
    ev(3'b010);
    ev(3'b001);
    rd(8'he8, d);
    chk("flags", d, 8'h03);
    wr(8'he8, 8'h7e);
    chk("wd_restart", {7'h00, wdr}, 8'h00);
    chk("flags", {6'h00, sf, xf}, 8'h02);
    wr(8'he8, 8'hff);
    chk("wd_restart", {7'h00, wdr}, 8'h01);
    chk("flags", {6'h00, sf, xf}, 8'h02);
    wr(8'he8, 8'hfd);
    chk("flags", {6'h00, sf, xf}, 8'h00);
    // busy event and clearing write on the same edge: set wins
    fork
      wr(8'he8, 8'hfe);
      ev(3'b010);
    join
    chk("flags_collide", {6'h00, sf, xf}, 8'h01);
    chk("wd_restart", {7'h00, wdr}, 8'h01);
    $display("test flags done");
    ext = 7'h5a;
    repeat (3) @(posedge clk);
    rd(8'hf8, d);
    chk("irq_levels", d, 8'h5a);
    ext = 7'h25;
    repeat (3) @(posedge clk);
    rd(8'hf8, d);
    chk("irq_levels", d, 8'h25);
    $display("test pin levels done");
    close_out();
  end
endmodule : tb_top

// >>> core/fwm_defs.svh
// fwm_defs.svh: addresses, field positions, reset values and trigger codes of the sfr bank
// assumes: included by bare name by the package; the bank module uses its macros without including it
`ifndef FWM_DEFS_SVH
`define FWM_DEFS_SVH

// special function addresses
`define FWM_ADDR_ERASE_TRIG 8'h94
`define FWM_ADDR_EE_BYTE 8'h9e
`define FWM_ADDR_EE_CMD 8'h9f
`define FWM_ADDR_FLASH_CTRL 8'hb2
`define FWM_ADDR_PAGE_SEL 8'hb7
`define FWM_ADDR_WDI_FLAGS 8'he8
`define FWM_ADDR_IRQ_LEVELS 8'hf8

// erase trigger codes
`define FWM_TRIG_PAGE 8'h55
`define FWM_TRIG_MASS 8'haa

// flash control field positions
`define FWM_BIT_PWE 0
`define FWM_BIT_MEEN 1
`define FWM_BIT_READ_PROTECTION 6
`define FWM_BIT_PREBOOT 7

// multi-purpose flag field positions
`define FWM_BIT_XFER_FLAG 0
`define FWM_BIT_SEC_FLAG 1
`define FWM_BIT_WD_RESTART 7

// reset values
`define FWM_RST_ERASE_TRIG 8'h00
`define FWM_RST_PAGE_SEL 7'h00
`define FWM_RST_EE_BYTE 8'h00
`define FWM_RST_EE_CMD 8'h00

`endif

// >>> core/fwm_pkg.sv
// fwm_pkg.sv: types shared by the sfr bank files
// assumes: fwm_defs.svh on the include path
`include "fwm_defs.svh"
package fwm_pkg;
  // erase request state, one-hot
  typedef enum logic [2:0] {
    FWM_ER_IDLE = 3'b001,
    FWM_ER_PAGE = 3'b010,
    FWM_ER_MASS = 3'b100
  } fwm_erase_t;
endpackage : fwm_pkg

// >>> core/fwm_sfr_bank.sv
// fwm_sfr_bank.sv: device sfr bank for flash erase/write control, eeprom launch, flags, watchdog restart
// assumes: mpu sfr port with one-cycle wr/rd strobes on sys_clk_i; event inputs from same clock
//
// Overview of operation
// - writing 0x55 to erase trigger starts one page erase of selected page, if page select written since last page erase
// - writing 0xaa starts mass erase if mass enable set and debug port on
// - any other trigger value is ignored, no erase starts
// - erase trigger lives at 0x94, write-only, resets to zero
// - page select at 0xb7 is read/write, holds page 0..127, resets zero
// - writing command register 0x9f launches eeprom transfer of byte at 0x9e
// - program write enable set steers data-pointer writes into flash at pointer
// - program write enable clears itself after each flash byte written
// - program write enable writes blocked while interrupts globally enabled
// - mass erase enable is write-only, default off, consumed by each mass erase
// - read protection bit set-only, cleared only by reset, blocks external reads
// - bit 7 of flash control reads one while preboot runs
// - transfer flag set by hardware on transfer-busy event, held until cleared
// - second flag set by hardware on one-second event, held until cleared
// - writing one to bit 7 of flag register restarts watchdog, write-only
// - 0xf8 reads live external interrupt input levels zero through six
`timescale 1ns/1ps
module fwm_sfr_bank
  import fwm_pkg::*;
#(
  parameter int IRQ_W = 7
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic global_irq_en_i,
  input wire logic debug_port_en_i,
  input wire logic preboot_active_i,
  input wire logic flash_byte_done_i,
  input wire logic transfer_busy_event_i,
  input wire logic one_second_event_i,
  input wire logic [IRQ_W-1:0] ext_irq_inputs_i,
  output logic page_erase_start_o,
  output logic mass_erase_start_o,
  output logic [6:0] erase_page_o,
  output logic program_write_enable_o,
  output logic read_protection_o,
  output logic [7:0] serial_eeprom_byte_o,
  output logic [7:0] serial_eeprom_command_o,
  output logic eeprom_launch_o,
  output logic watchdog_restart_o,
  output logic transfer_done_flag_o,
  output logic second_tick_flag_o
);
  logic [IRQ_W-1:0] irq_sync;
  logic [7:0] trig_ff, nxt_trig;
  logic [6:0] page_ff, nxt_page;
  logic page_armed_ff, nxt_page_armed;
  logic pwe_ff, nxt_pwe;
  logic meen_ff, nxt_meen;
  logic read_protection_ff, nxt_read_protection;
  logic [7:0] ee_byte_ff, nxt_ee_byte;
  logic [7:0] ee_cmd_ff, nxt_ee_cmd;
  logic launch_ff, nxt_launch;
  logic xfer_flag_ff, nxt_xfer_flag;
  logic sec_flag_ff, nxt_sec_flag;
  logic wd_ff, nxt_wd;
  logic [7:0] rdata_ff, nxt_rdata;
  fwm_erase_t er_ff, nxt_er;

  // write decode for one address
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target, input logic wr);
    wr_hit = wr && (a == target);
  endfunction : wr_hit

  // external interrupt pins come from outside the clock domain
  fwm_sync #(.W(IRQ_W)) u_irq_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i(ext_irq_inputs_i),
    .sync_o(irq_sync)
  );

  // flash control, erase and eeprom next state
  always_comb
  begin
    nxt_trig = trig_ff;
    nxt_page = page_ff;
    nxt_page_armed = page_armed_ff;
    nxt_pwe = pwe_ff;
    nxt_meen = meen_ff;
    nxt_read_protection = read_protection_ff;
    nxt_ee_byte = ee_byte_ff;
    nxt_ee_cmd = ee_cmd_ff;
    nxt_launch = 1'b0;
    nxt_er = FWM_ER_IDLE;
    if (wr_hit(sfr_addr_i, `FWM_ADDR_PAGE_SEL, sfr_wr_i))
    begin
      nxt_page = sfr_wdata_i[6:0];
      nxt_page_armed = 1'b1;
    end
    if (wr_hit(sfr_addr_i, `FWM_ADDR_FLASH_CTRL, sfr_wr_i))
    begin
      if (!global_irq_en_i)
        nxt_pwe = sfr_wdata_i[`FWM_BIT_PWE];
      nxt_meen = sfr_wdata_i[`FWM_BIT_MEEN];
      nxt_read_protection = read_protection_ff | sfr_wdata_i[`FWM_BIT_READ_PROTECTION];
    end
    if (flash_byte_done_i && pwe_ff)
      nxt_pwe = 1'b0;
    if (wr_hit(sfr_addr_i, `FWM_ADDR_ERASE_TRIG, sfr_wr_i))
    begin
      nxt_trig = sfr_wdata_i;
      if (sfr_wdata_i == `FWM_TRIG_PAGE && page_armed_ff)
      begin
        nxt_er = FWM_ER_PAGE;
        nxt_page_armed = 1'b0;
      end
      else if (sfr_wdata_i == `FWM_TRIG_MASS && meen_ff && debug_port_en_i)
      begin
        nxt_er = FWM_ER_MASS;
        nxt_meen = 1'b0;
      end
    end
    if (wr_hit(sfr_addr_i, `FWM_ADDR_EE_BYTE, sfr_wr_i))
      nxt_ee_byte = sfr_wdata_i;
    if (wr_hit(sfr_addr_i, `FWM_ADDR_EE_CMD, sfr_wr_i))
    begin
      nxt_ee_cmd = sfr_wdata_i;
      nxt_launch = 1'b1;
    end
  end

  // multi-purpose flag next state
  always_comb
  begin
    nxt_xfer_flag = xfer_flag_ff;
    nxt_sec_flag = sec_flag_ff;
    nxt_wd = 1'b0; // restart is a one-cycle pulse, only this process drives it
    if (wr_hit(sfr_addr_i, `FWM_ADDR_WDI_FLAGS, sfr_wr_i))
    begin
      nxt_xfer_flag = xfer_flag_ff & sfr_wdata_i[`FWM_BIT_XFER_FLAG];
      nxt_sec_flag = sec_flag_ff & sfr_wdata_i[`FWM_BIT_SEC_FLAG];
      nxt_wd = sfr_wdata_i[`FWM_BIT_WD_RESTART];
    end
    if (transfer_busy_event_i)
      nxt_xfer_flag = 1'b1;
    if (one_second_event_i)
      nxt_sec_flag = 1'b1;
  end

  // read mux, registered
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (sfr_rd_i)
    begin
      unique case (sfr_addr_i)
        `FWM_ADDR_PAGE_SEL: nxt_rdata = {1'b0, page_ff};
        `FWM_ADDR_EE_BYTE: nxt_rdata = ee_byte_ff;
        `FWM_ADDR_EE_CMD: nxt_rdata = ee_cmd_ff;
        `FWM_ADDR_FLASH_CTRL: nxt_rdata = {preboot_active_i, read_protection_ff, 5'h00, pwe_ff};
        `FWM_ADDR_WDI_FLAGS: nxt_rdata = {6'h00, sec_flag_ff, xfer_flag_ff};
        `FWM_ADDR_IRQ_LEVELS: nxt_rdata = {{(8-IRQ_W){1'b0}}, irq_sync};
        default: nxt_rdata = 8'h00; // write-only and unmapped read zero
      endcase
    end
  end

  // state registers
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      trig_ff <= `FWM_RST_ERASE_TRIG;
      page_ff <= `FWM_RST_PAGE_SEL;
      page_armed_ff <= 1'b0;
      pwe_ff <= 1'b0;
      meen_ff <= 1'b0;
      read_protection_ff <= 1'b0;
      ee_byte_ff <= `FWM_RST_EE_BYTE;
      ee_cmd_ff <= `FWM_RST_EE_CMD;
      launch_ff <= 1'b0;
      xfer_flag_ff <= 1'b0;
      sec_flag_ff <= 1'b0;
      wd_ff <= 1'b0;
      rdata_ff <= 8'h00;
      er_ff <= FWM_ER_IDLE;
    end
    else
    begin
      trig_ff <= nxt_trig;
      page_ff <= nxt_page;
      page_armed_ff <= nxt_page_armed;
      pwe_ff <= nxt_pwe;
      meen_ff <= nxt_meen;
      read_protection_ff <= nxt_read_protection;
      ee_byte_ff <= nxt_ee_byte;
      ee_cmd_ff <= nxt_ee_cmd;
      launch_ff <= nxt_launch;
      xfer_flag_ff <= nxt_xfer_flag;
      sec_flag_ff <= nxt_sec_flag;
      wd_ff <= nxt_wd;
      rdata_ff <= nxt_rdata;
      er_ff <= nxt_er;
    end
  end

  // outputs straight from flops
  assign sfr_rdata_o = rdata_ff;
  assign page_erase_start_o = (er_ff == FWM_ER_PAGE);
  assign mass_erase_start_o = (er_ff == FWM_ER_MASS);
  assign erase_page_o = page_ff;
  assign program_write_enable_o = pwe_ff;
  assign read_protection_o = read_protection_ff;
  assign serial_eeprom_byte_o = ee_byte_ff;
  assign serial_eeprom_command_o = ee_cmd_ff;
  assign eeprom_launch_o = launch_ff;
  assign watchdog_restart_o = wd_ff;
  assign transfer_done_flag_o = xfer_flag_ff;
  assign second_tick_flag_o = sec_flag_ff;

  property p_page_erase;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (sfr_wr_i && sfr_addr_i == 8'h94 && sfr_wdata_i == 8'h55 && page_armed_ff) |=> page_erase_start_o;
  endproperty
  a_page_erase: assert property (p_page_erase) else $error("page erase not started");

  property p_mass_erase;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    mass_erase_start_o |-> $past(sfr_wr_i) && ($past(sfr_addr_i) == 8'h94) && $past(meen_ff)
      && $past(debug_port_en_i) && ($past(sfr_wdata_i) == 8'haa);
  endproperty
  a_mass_erase: assert property (p_mass_erase) else $error("mass erase without its conditions");

  property p_other_ignored;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (sfr_wr_i && sfr_addr_i == 8'h94 && sfr_wdata_i != 8'h55 && sfr_wdata_i != 8'haa)
      |=> !page_erase_start_o && !mass_erase_start_o;
  endproperty
  a_other_ignored: assert property (p_other_ignored) else $error("erase from unknown pattern");

  property p_stale_page;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    page_erase_start_o |-> !page_armed_ff;
  endproperty
  a_stale_page: assert property (p_stale_page) else $error("page select not consumed");

  property p_launch;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (sfr_wr_i && sfr_addr_i == 8'h9f) |=> eeprom_launch_o && serial_eeprom_command_o == $past(sfr_wdata_i);
  endproperty
  a_launch: assert property (p_launch) else $error("eeprom launch missing");

  property p_pwe_clear;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (flash_byte_done_i && pwe_ff) |=> !program_write_enable_o;
  endproperty
  a_pwe_clear: assert property (p_pwe_clear) else $error("pwe not self cleared");

  property p_pwe_block;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (global_irq_en_i && !flash_byte_done_i) |=> $stable(program_write_enable_o);
  endproperty
  a_pwe_block: assert property (p_pwe_block) else $error("pwe changed with irqs on");

  property p_read_protection_sticky;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    read_protection_o |=> read_protection_o;
  endproperty
  a_read_protection_sticky: assert property (p_read_protection_sticky) else $error("protection cleared");

  property p_xfer_flag;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    transfer_busy_event_i |=> transfer_done_flag_o;
  endproperty
  a_xfer_flag: assert property (p_xfer_flag) else $error("transfer flag not set");

  property p_sec_flag;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (second_tick_flag_o && !(sfr_wr_i && sfr_addr_i == 8'he8 && !sfr_wdata_i[1])) |=> second_tick_flag_o;
  endproperty
  a_sec_flag: assert property (p_sec_flag) else $error("second flag lost");

  property p_wd;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (sfr_wr_i && sfr_addr_i == 8'he8 && sfr_wdata_i[7]) |=> watchdog_restart_o
      ##1 (watchdog_restart_o == $past(sfr_wr_i && sfr_addr_i == 8'he8 && sfr_wdata_i[7]));
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog restart pulse wrong");
endmodule : fwm_sfr_bank

// >>> core/fwm_sync.sv
// fwm_sync.sv: two-flop synchroniser for a vector of pin levels
// assumes: destination clock is sys_clk_i, async active-low reset
`timescale 1ns/1ps
module fwm_sync #(
  parameter int W = 7
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // first stage feeds only the second
  always_comb
  begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff;
endmodule : fwm_sync
